// ===== hw/lpmc_pkg.sv
package lpmc_pkg;
    // Power modes
    typedef enum logic [1:0] {
        LPMC_MODE_RUN,
        LPMC_MODE_SLEEP,
        LPMC_MODE_STOP,
        LPMC_MODE_STANDBY
    } lpmc_mode_t;

    localparam int LPMC_EXT_LINES = 16;
    localparam int LPMC_RTC_EVENTS = 4;
    // Time the core reset is held on exit from standby, in ns and in cycles
    localparam int LPMC_RESET_HOLD_NS = 1000;
    localparam int LPMC_CLK_PERIOD_NS = 40;
    localparam int LPMC_RESET_HOLD_CYC = (LPMC_RESET_HOLD_NS + LPMC_CLK_PERIOD_NS - 1) / LPMC_CLK_PERIOD_NS;
    localparam logic LPMC_UNDERDRIVE_RST = 1'b0;
    localparam logic LPMC_USE_LPR_RST = 1'b0;
endpackage

// ===== hw/lpmc_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - Sleep halts only the core; any peripheral interrupt or event wakes it.
// - Stop gates core-domain clocks, disables PLL and both oscillators, keeps contents.
// - In stop the regulator is main or low-power, normal or under-drive.
// - Stop ends on any external event line, detector, RTC or USB wakeup.
// - Standby powers off regulator, core domain, oscillators and PLL.
// - Standby ends on reset pin, watchdog reset, wakeup pin rise or RTC event.
// - Standby is refused while the regulator is bypassed by external supply.
// - Battery domain switches to the battery pin whenever main supply is absent.
// - Backup SRAM takes core-only writes, guarded, retained in standby and battery.
module lpmc_ctrl #(
    parameter int EXT_LINES = lpmc_pkg::LPMC_EXT_LINES,
    parameter int RESET_HOLD_CYC = lpmc_pkg::LPMC_RESET_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Mode requests from the core
    input wire logic sleep_req,
    input wire logic deep_req,
    input wire logic standby_sel,
    input wire logic stop_use_lpr,
    input wire logic stop_underdrive,
    input wire logic regulator_bypass,
    // Wake sources
    input wire logic periph_event,
    input wire logic [EXT_LINES-1:0] external_event_lines,
    input wire logic supply_voltage_detector,
    input wire logic [3:0] rtc_events,
    input wire logic usb_wakeup,
    input wire logic external_reset_pin_n,
    input wire logic independent_watchdog,
    input wire logic wakeup_pin,
    // Supply and backup SRAM
    input wire logic main_supply_ok,
    input wire logic bkp_wr_req,
    input wire logic bkp_wr_from_core,
    input wire logic bkp_wr_unlock,
    // Outputs
    output logic [1:0] mode,
    output logic core_clk_en,
    output logic domain_clk_en,
    output logic pll_en,
    output logic internal_rc_oscillator_en,
    output logic external_crystal_oscillator_en,
    output logic main_regulator_on,
    output logic low_power_regulator_on,
    output logic regulator_underdrive,
    output logic core_domain_power,
    output logic core_reset_n,
    output logic battery_supply_domain_sel,
    output logic bkp_wr_en
);
    lpmc_pkg::lpmc_mode_t mode_reg, mode_next;
    logic [2:0] rst_pin_sync_reg, wakeup_pin_sync_reg, sup_sync_reg;
    logic rst_pin_seen_reg, wakeup_pin_seen_reg, sup_seen_reg;
    logic [EXT_LINES+5:0] evt_s1_reg, evt_s2_reg, evt_s3_reg;
    logic wakeup_pin_prev_reg;
    logic [$clog2(RESET_HOLD_CYC+1)-1:0] hold_reg;
    logic stop_wake, standby_wake, wakeup_pin_rise, rst_pin_low;

    // Three-stage sampling; stages two and three must agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pin_sync_reg <= 3'h7;
            wakeup_pin_sync_reg <= 3'h0;
            sup_sync_reg <= 3'h7;
            evt_s1_reg <= '0;
            evt_s2_reg <= '0;
            evt_s3_reg <= '0;
        end else begin
            rst_pin_sync_reg <= {rst_pin_sync_reg[1:0], external_reset_pin_n};
            wakeup_pin_sync_reg <= {wakeup_pin_sync_reg[1:0], wakeup_pin};
            sup_sync_reg <= {sup_sync_reg[1:0], main_supply_ok};
            evt_s1_reg <= {external_event_lines, supply_voltage_detector, rtc_events, usb_wakeup};
            evt_s2_reg <= evt_s1_reg;
            evt_s3_reg <= evt_s2_reg;
        end
    end

    // Settled levels, updated only when stages agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pin_seen_reg <= 1'b1;
            wakeup_pin_seen_reg <= 1'b0;
            sup_seen_reg <= 1'b1;
            wakeup_pin_prev_reg <= 1'b0;
        end else begin
            if (rst_pin_sync_reg[1] == rst_pin_sync_reg[2]) begin
                rst_pin_seen_reg <= rst_pin_sync_reg[2];
            end
            if (wakeup_pin_sync_reg[1] == wakeup_pin_sync_reg[2]) begin
                wakeup_pin_seen_reg <= wakeup_pin_sync_reg[2];
            end
            if (sup_sync_reg[1] == sup_sync_reg[2]) begin
                sup_seen_reg <= sup_sync_reg[2];
            end
            wakeup_pin_prev_reg <= wakeup_pin_seen_reg;
        end
    end

    assign wakeup_pin_rise = wakeup_pin_seen_reg && !wakeup_pin_prev_reg;
    assign rst_pin_low = !rst_pin_seen_reg;
    // Event lines only count when both late stages agree high
    assign stop_wake = |(evt_s2_reg & evt_s3_reg);
    assign standby_wake = rst_pin_low || independent_watchdog || wakeup_pin_rise
        || |(evt_s2_reg[4:1] & evt_s3_reg[4:1]);

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            lpmc_pkg::LPMC_MODE_RUN: begin
                if (deep_req && standby_sel && !regulator_bypass) begin
                    mode_next = lpmc_pkg::LPMC_MODE_STANDBY;
                end else if (deep_req) begin
                    mode_next = lpmc_pkg::LPMC_MODE_STOP;
                end else if (sleep_req) begin
                    mode_next = lpmc_pkg::LPMC_MODE_SLEEP;
                end
            end
            lpmc_pkg::LPMC_MODE_SLEEP: begin
                if (periph_event || stop_wake) begin
                    mode_next = lpmc_pkg::LPMC_MODE_RUN;
                end
            end
            lpmc_pkg::LPMC_MODE_STOP: begin
                if (stop_wake) begin
                    mode_next = lpmc_pkg::LPMC_MODE_RUN;
                end
            end
            lpmc_pkg::LPMC_MODE_STANDBY: begin
                if (standby_wake) begin
                    mode_next = lpmc_pkg::LPMC_MODE_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= lpmc_pkg::LPMC_MODE_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Reset hold counter after standby exit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= '0;
        end else if (mode_reg == lpmc_pkg::LPMC_MODE_STANDBY && mode_next == lpmc_pkg::LPMC_MODE_RUN) begin
            hold_reg <= ($clog2(RESET_HOLD_CYC+1))'(RESET_HOLD_CYC);
        end else if (hold_reg != '0) begin
            hold_reg <= hold_reg - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= 2'h0;
            core_clk_en <= 1'b1;
            domain_clk_en <= 1'b1;
            pll_en <= 1'b1;
            internal_rc_oscillator_en <= 1'b1;
            external_crystal_oscillator_en <= 1'b1;
            main_regulator_on <= 1'b1;
            low_power_regulator_on <= lpmc_pkg::LPMC_USE_LPR_RST;
            regulator_underdrive <= lpmc_pkg::LPMC_UNDERDRIVE_RST;
            core_domain_power <= 1'b1;
        end else begin
            mode <= mode_next;
            core_clk_en <= mode_next == lpmc_pkg::LPMC_MODE_RUN;
            domain_clk_en <= domain_clk_en_f(mode_next);
            pll_en <= domain_clk_en_f(mode_next);
            internal_rc_oscillator_en <= domain_clk_en_f(mode_next);
            external_crystal_oscillator_en <= domain_clk_en_f(mode_next);
            if (mode_next == lpmc_pkg::LPMC_MODE_STOP) begin
                main_regulator_on <= !stop_use_lpr;
                low_power_regulator_on <= stop_use_lpr;
                regulator_underdrive <= stop_underdrive;
            end else begin
                main_regulator_on <= !standby_f(mode_next);
                low_power_regulator_on <= 1'b0;
                regulator_underdrive <= 1'b0;
            end
            core_domain_power <= !standby_f(mode_next);
        end
    end

    // Core reset low on standby entry and exit, so a core that lost power never runs early
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reset_n <= 1'b0;
        end else begin
            // Pin reset also restarts the core in run mode
            core_reset_n <= hold_reg == '0 && !standby_f(mode_reg) && !standby_f(mode_next)
                && !rst_pin_low;
        end
    end

    function automatic logic domain_clk_en_f(lpmc_pkg::lpmc_mode_t m);
        return m == lpmc_pkg::LPMC_MODE_RUN || m == lpmc_pkg::LPMC_MODE_SLEEP;
    endfunction

    function automatic logic standby_f(lpmc_pkg::lpmc_mode_t m);
        return m == lpmc_pkg::LPMC_MODE_STANDBY;
    endfunction

    // Battery switch and backup SRAM guard
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            battery_supply_domain_sel <= 1'b0;
            bkp_wr_en <= 1'b0;
        end else begin
            battery_supply_domain_sel <= !sup_seen_reg;
            // Retention: no write reaches SRAM outside run or on battery
            bkp_wr_en <= bkp_wr_req && bkp_wr_from_core && bkp_wr_unlock && sup_seen_reg
                && mode_reg == lpmc_pkg::LPMC_MODE_RUN;
        end
    end
endmodule

// ===== tb/lpmc_checker.sv
`timescale 1ns/100ps
module lpmc_checker #(
    parameter int EXT_LINES = 16
) (
    // Clock, reset and requests
    input wire logic sys_clk, rst_n, deep_req, standby_sel, stop_use_lpr, stop_underdrive, regulator_bypass,
    // Wake sources and write qualifiers
    input wire logic [EXT_LINES-1:0] external_event_lines,
    input wire logic external_reset_pin_n, main_supply_ok, bkp_wr_req, bkp_wr_from_core, bkp_wr_unlock,
    // Watched outputs
    input wire logic [1:0] mode,
    input wire logic core_clk_en, domain_clk_en, pll_en, internal_rc_oscillator_en, external_crystal_oscillator_en,
    input wire logic main_regulator_on, low_power_regulator_on, regulator_underdrive, core_domain_power,
    input wire logic core_reset_n, battery_supply_domain_sel, bkp_wr_en
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sleep_core_a: assert property (mode == 2'h1 |-> !core_clk_en && domain_clk_en && pll_en)
        else $error("sleep gated more than the core");
    stop_clocks_a: assert property (mode == 2'h2 |-> !(domain_clk_en || pll_en ||
        internal_rc_oscillator_en || external_crystal_oscillator_en)) else $error("clock left on in stop");
    stop_regulator_a: assert property (mode == 2'h0 && deep_req && !standby_sel |=> mode == 2'h2 &&
        low_power_regulator_on == $past(stop_use_lpr) && regulator_underdrive == $past(stop_underdrive))
        else $error("stop regulator setting wrong");
    stop_wake_a: assert property (mode == 2'h2 && |external_event_lines |-> ##[1:6] mode == 2'h0)
        else $error("event line did not end stop");
    standby_power_a: assert property (mode == 2'h3 |-> !(core_domain_power || main_regulator_on ||
        pll_en || core_reset_n)) else $error("standby left power on");
    standby_wake_a: assert property (mode == 2'h3 && !external_reset_pin_n |-> ##[1:6] mode == 2'h0)
        else $error("reset pin did not end standby");
    bypass_stop_a: assert property (mode == 2'h0 && deep_req && regulator_bypass |=> mode == 2'h2)
        else $error("standby taken with bypass");
    battery_switch_a: assert property (!main_supply_ok [*6] |-> battery_supply_domain_sel)
        else $error("battery not selected");
    backup_guard_a: assert property (bkp_wr_en |-> $past(bkp_wr_req) && $past(bkp_wr_from_core) &&
        $past(bkp_wr_unlock) && $past(mode) == 2'h0) else $error("unguarded backup write");
    standby_exit_a: assert property (mode == 2'h0 && $past(mode) == 2'h3 |-> !core_reset_n)
        else $error("standby exit skipped reset");
    cover property (mode == 2'h1);
    cover property (mode == 2'h2 ##1 mode == 2'h0);
    cover property (mode == 2'h3 ##1 mode == 2'h0);
    cover property (bkp_wr_en);
endmodule

// ===== tb/lpmc_wake_src.sv
`timescale 1ns/100ps
module lpmc_wake_src (
    // Command from the bench
    input wire logic sys_clk, go,
    input wire logic [2:0] kind,
    input wire logic [3:0] idx,
    // Wake sources
    output logic [15:0] external_event_lines,
    output logic supply_voltage_detector, usb_wakeup, wakeup_pin, external_reset_pin_n,
    output logic [3:0] rtc_events
);
    // Held eight cycles so the wake synchroniser surely sees it
    always @(posedge sys_clk) begin
        if (go) begin
            #2;
            case (kind)
                3'h0: external_event_lines[idx] = 1'b1;
                3'h1: supply_voltage_detector = 1'b1;
                3'h2: rtc_events[idx[1:0]] = 1'b1;
                3'h3: usb_wakeup = 1'b1;
                3'h4: wakeup_pin = 1'b1;
                default: external_reset_pin_n = 1'b0;
            endcase
            repeat (8) @(posedge sys_clk);
        end
        // Idle levels also go out just after the edge, never on it
        #2;
        {external_event_lines, supply_voltage_detector, usb_wakeup, wakeup_pin, rtc_events} = '0;
        external_reset_pin_n = 1'b1;
    end
endmodule

// ===== tb/low_power_mode_controller_test.sv
`timescale 1ns/100ps
module low_power_mode_controller_test;
    logic sys_clk = 0, rst_n = 0, go = 0, sleep_req = 0, deep_req = 0, standby_sel = 0, stop_use_lpr = 0;
    logic stop_underdrive = 0, regulator_bypass = 0, periph_event = 0, independent_watchdog = 0, main_supply_ok = 1;
    logic bkp_wr_req = 0, bkp_wr_from_core = 0, bkp_wr_unlock = 0;
    logic [2:0] kind = 0;
    logic [3:0] idx = 0, rtc_events;
    logic [15:0] external_event_lines;
    logic supply_voltage_detector, usb_wakeup, wakeup_pin, external_reset_pin_n;
    logic [1:0] mode;
    logic core_clk_en, domain_clk_en, pll_en, internal_rc_oscillator_en, external_crystal_oscillator_en;
    logic main_regulator_on, low_power_regulator_on, regulator_underdrive, core_domain_power, core_reset_n;
    logic battery_supply_domain_sel, bkp_wr_en;
    int n_errors = 0, num_checks = 0, exp_mode, k;
    always #20 sys_clk = ~sys_clk;
    // Short reset hold keeps standby exits quick
    lpmc_ctrl #(.RESET_HOLD_CYC(2)) dut (.*);
    lpmc_wake_src partner (.*);
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic enter(input logic s, d, sel, input int e);
        {sleep_req, deep_req, standby_sel} = {s, d, sel};
        exp_mode = e;
        step(1);
        {sleep_req, deep_req} = 2'h0;
        check(mode, 4'(exp_mode));
    endtask
    task automatic fire(input logic [2:0] kd);
        kind = kd;
        idx = 4'($urandom);
        go = 1'b1;
        step(1);
        go = 1'b0;
    endtask
    task automatic wait_run(input logic rn);
        for (k = 0; k < 30 && mode !== 2'h0; k++)
            step(1);
        if (mode !== 2'h0) begin
            n_errors++;
            $display("[FAIL] %0t no wake within 30 cycles", $time);
            tally_and_finish();
        end
        check({mode, core_reset_n}, {2'h0, rn});
        step(14);
        check(core_reset_n, 4'h1);
    endtask
    initial begin
        void'($urandom(60273));
        step(12);
        rst_n = 1'b1;
        step(2);
        enter(1'b1, 1'b0, 1'b0, 1);
        check({core_clk_en, domain_clk_en, pll_en}, 4'h3);
        periph_event = 1'b1;
        step(1);
        periph_event = 1'b0;
        wait_run(1'b1);
        for (int i = 0; i < 4; i++) begin
            {stop_use_lpr, stop_underdrive} = 2'($urandom);
            regulator_bypass = i[0];
            enter(1'b0, 1'b1, i[0], 2);
            check({low_power_regulator_on, main_regulator_on, regulator_underdrive},
                {1'b0, stop_use_lpr, !stop_use_lpr, stop_underdrive});
            check({pll_en, internal_rc_oscillator_en, external_crystal_oscillator_en}, 4'h0);
            fire(3'(i));
            wait_run(1'b1);
        end
        regulator_bypass = 1'b0;
        for (int j = 0; j < 5; j++) begin
            enter(1'b0, 1'b1, 1'b1, 3);
            check({core_domain_power, main_regulator_on, internal_rc_oscillator_en, core_reset_n}, 4'h0);
            if (j == 4) begin
                independent_watchdog = 1'b1;
                step(1);
                independent_watchdog = 1'b0;
            end else if (j == 1) begin
                // A USB wake ends stop and sleep, but not standby
                fire(3'h3);
                step(10);
                check(mode, 4'h3);
                fire(3'h2);
            end else fire(3'(j + 2));
            wait_run(1'b0);
        end
        // Supply loss and every write qualifier combination
        for (int n = 0; n < 16; n++) begin
            {main_supply_ok, bkp_wr_req, bkp_wr_from_core, bkp_wr_unlock} = 4'(n);
            step(7);
            check({battery_supply_domain_sel, bkp_wr_en}, {2'h0, !main_supply_ok, n == 15});
        end
        // Reset while in stop returns to run with the core held in reset
        enter(1'b0, 1'b1, 1'b0, 2);
        rst_n = 1'b0;
        step(1);
        check({mode, core_reset_n, core_clk_en}, 4'h1);
        rst_n = 1'b1;
        step(2);
        check({mode, core_reset_n, core_clk_en}, 4'h3);
        tally_and_finish();
    end
endmodule
bind lpmc_ctrl lpmc_checker #(.EXT_LINES(EXT_LINES)) chk (.*);
